// *** inc/sirq_map.svh ***
// Purpose: Register offsets, field positions and reset values of the serial
//          interrupt routing block.
// Assumes: 8-bit byte address, 32-bit data words, one word per register.
// Notes:   Definitions only.
`ifndef SIRQ_MAP_SVH
`define SIRQ_MAP_SVH

`define SIRQ_NCH 12
`define SIRQ_AW 8

`define SIRQ_PROT_OFS 8'h00
`define SIRQ_STOP_OFS 8'h04
`define SIRQ_GSRC_OFS 8'h08
`define SIRQ_GEN_OFS 8'h0c
`define SIRQ_ISTAT_OFS 8'h10
`define SIRQ_IMASK_OFS 8'h14
`define SIRQ_CH_PAGE 2'h1

`define SIRQ_PROT_KEY 8'ha5
`define SIRQ_PROT_KEY_LSB 8
`define SIRQ_PROT_UNLOCK 0
`define SIRQ_STOP_RST 12'hfff

`define SIRQ_CH_RF 0
`define SIRQ_CH_TE 1
`define SIRQ_CH_TN 2
`define SIRQ_CH_ER 3
`define SIRQ_CH_OVR 4
`define SIRQ_CH_FER 5
`define SIRQ_CH_PER 6
`define SIRQ_CH_EN_LSB 8

`define SIRQ_IS_GERR 0
`define SIRQ_IS_REFUSED 1

`endif

// *** inc/sirq_pkg.sv ***
// Purpose: Types shared by the serial interrupt routing block.
// Assumes: Map header is on the include path.
// Notes:   Flag order matches the per-channel register layout.
`include "sirq_map.svh"

package sirq_pkg;

    typedef struct packed {
        logic parity;
        logic framing;
        logic overrun;
        logic tx_end;
        logic tx_empty;
        logic rx_full;
    } sirq_flags_t;

    typedef struct packed {
        logic tx_end;
        logic tx_empty;
        logic rx_full;
    } sirq_ack_t;

    typedef struct packed {
        logic [`SIRQ_AW-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } sirq_bus_t;

endpackage

// *** src/sirq_prot.sv ***
// Purpose: Write protection and module stop control for all channels.
// Assumes: Strobes come from logic on the same clock.
// Notes:   Every channel starts stopped.
`timescale 1ns/1ps
`default_nettype none
`include "sirq_map.svh"

module sirq_prot import sirq_pkg::*; (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic prot_wr_i,
    input wire logic stop_wr_i,
    input wire logic [31:0] wdata_i,
    output logic unlocked_o,
    output logic [`SIRQ_NCH-1:0] stop_o,
    output logic refused_o
);
    typedef struct packed {
        logic unlocked;
        logic [`SIRQ_NCH-1:0] stop;
        logic refused;
    } sirq_prot_st_t;

    sirq_prot_st_t st_reg;
    sirq_prot_st_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.refused = 1'b0;
        // A wrong key leaves the protection as it was.
        if (prot_wr_i && wdata_i[`SIRQ_PROT_KEY_LSB +: 8] == `SIRQ_PROT_KEY) begin
            st_next.unlocked = wdata_i[`SIRQ_PROT_UNLOCK];
        end
        if (stop_wr_i) begin
            if (st_reg.unlocked) begin
                st_next.stop = wdata_i[`SIRQ_NCH-1:0];
            end else begin
                st_next.refused = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            st_reg.unlocked <= 1'b0;
            st_reg.stop <= `SIRQ_STOP_RST;
            st_reg.refused <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign unlocked_o = st_reg.unlocked;
    assign stop_o = st_reg.stop;
    assign refused_o = st_reg.refused;
endmodule // sirq_prot

`default_nettype wire

// *** src/sirq_chan.sv ***
// Purpose: Request and error flags of one serial channel.
// Assumes: Events, acknowledges and strobes are on the core clock.
// Notes:   Flags set regardless of their enables, so they can be polled.
`timescale 1ns/1ps
`default_nettype none
`include "sirq_map.svh"

module sirq_chan import sirq_pkg::*; (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic run_i,
    input wire logic wr_i,
    input wire logic [31:0] wdata_i,
    input wire sirq_flags_t evt_i,
    input wire sirq_ack_t ack_i,
    output sirq_flags_t flags_o,
    output logic [3:0] en_o
);
    typedef struct packed {
        sirq_flags_t flags;
        logic [3:0] en;
    } sirq_chan_st_t;

    sirq_chan_st_t st_reg;
    sirq_chan_st_t st_next;
    sirq_flags_t clr;

    always_comb begin
        st_next = st_reg;
        clr = '0;
        if (wr_i) begin
            clr.rx_full = wdata_i[`SIRQ_CH_RF];
            clr.tx_empty = wdata_i[`SIRQ_CH_TE];
            clr.tx_end = wdata_i[`SIRQ_CH_TN];
            clr.overrun = wdata_i[`SIRQ_CH_OVR];
            clr.framing = wdata_i[`SIRQ_CH_FER];
            clr.parity = wdata_i[`SIRQ_CH_PER];
            st_next.en = wdata_i[`SIRQ_CH_EN_LSB +: 4];
        end
        clr.rx_full = clr.rx_full | ack_i.rx_full;
        clr.tx_empty = clr.tx_empty | ack_i.tx_empty;
        clr.tx_end = clr.tx_end | ack_i.tx_end;
        // A new event in the clearing cycle wins over the clear.
        st_next.flags = (st_reg.flags & ~clr) | evt_i;
        if (!run_i) begin
            // A stopped channel holds everything idle.
            st_next = '0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flags_o = st_reg.flags;
    assign en_o = st_reg.en;
endmodule // sirq_chan

`default_nettype wire

// *** src/sirq_top.sv ***
// Purpose: Interrupt request routing for twelve serial channels, with a
//          grouped receive error request and module stop control.
// Assumes: Single core clock; channel events and processor acknowledges
//          are one-cycle pulses on that clock.
// Notes:   Registers are reached over a plain strobe port; read data
//          stand in the cycle after the read strobe.
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sirq_map.svh"

// Behaviour
// - Receive errors have no vector per channel.
// - All twelve channel errors raise one request.
// - Group source register holds one flag per channel.
// - Overrun, framing or parity raises receive error.
// - Channels start stopped and stay idle stopped.
// - Stop register writes blocked while protection active.
// - Four sources per channel, each with enable.
// - Transmit empty request when byte can be accepted.
// - Receive full request when byte is available.
// - Request flags stay readable and set when polled.
// - Processor acceptance clears the request flag.
module sirq_top import sirq_pkg::*; (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [`SIRQ_AW-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire sirq_flags_t [`SIRQ_NCH-1:0] evt_i,
    input wire sirq_ack_t [`SIRQ_NCH-1:0] ack_i,
    output logic [`SIRQ_NCH-1:0] receive_full_request_o,
    output logic [`SIRQ_NCH-1:0] transmit_empty_request_o,
    output logic [`SIRQ_NCH-1:0] transmit_end_request_o,
    output logic receive_error_request_o,
    output logic [`SIRQ_NCH-1:0] chan_stop_o,
    output logic irq_o
);
    typedef struct packed {
        logic [`SIRQ_NCH-1:0] group_error_enable_reg;
        logic [1:0] istat;
        logic [1:0] imask;
        logic [31:0] rdata;
        logic [`SIRQ_NCH-1:0] rf_req;
        logic [`SIRQ_NCH-1:0] te_req;
        logic [`SIRQ_NCH-1:0] tn_req;
        logic err_req;
        logic irq;
    } sirq_top_st_t;

    sirq_top_st_t st_reg;
    sirq_top_st_t st_next;
    sirq_bus_t bus;

    logic unlocked;
    logic [`SIRQ_NCH-1:0] stop;
    logic refused;
    logic prot_wr;
    logic stop_wr;
    logic ch_hit;
    logic [3:0] ch_idx;

    sirq_flags_t [`SIRQ_NCH-1:0] flags;
    logic [`SIRQ_NCH-1:0][3:0] en;
    logic [`SIRQ_NCH-1:0][31:0] ch_rdata;
    logic [`SIRQ_NCH-1:0] group_error_source_reg;
    logic [`SIRQ_NCH-1:0] chan_wr;

    assign bus.addr = addr_i;
    assign bus.wdata = wdata_i;
    assign bus.wr = wr_i;
    assign bus.rd = rd_i;

    // Channel registers occupy one word each in the second 64-byte page.
    assign ch_idx = bus.addr[5:2];
    assign ch_hit = (bus.addr[7:6] == `SIRQ_CH_PAGE) &&
        (ch_idx < 4'(`SIRQ_NCH)) && (bus.addr[1:0] == 2'h0);

    assign prot_wr = bus.wr && (bus.addr == `SIRQ_PROT_OFS);
    assign stop_wr = bus.wr && (bus.addr == `SIRQ_STOP_OFS);

    sirq_prot u_prot (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .prot_wr_i(prot_wr),
        .stop_wr_i(stop_wr),
        .wdata_i(bus.wdata),
        .unlocked_o(unlocked),
        .stop_o(stop),
        .refused_o(refused)
    );

    genvar ch;
    generate
        for (ch = 0; ch < `SIRQ_NCH; ch = ch + 1) begin : g_chan
            // Configuration writes to a stopped channel are dropped.
            assign chan_wr[ch] = bus.wr && ch_hit &&
                (ch_idx == 4'(ch)) && !stop[ch];

            sirq_chan u_chan (
                .core_clk_i(core_clk_i),
                .rst_b_i(rst_b_i),
                .run_i(!stop[ch]),
                .wr_i(chan_wr[ch]),
                .wdata_i(bus.wdata),
                .evt_i(evt_i[ch]),
                .ack_i(ack_i[ch]),
                .flags_o(flags[ch]),
                .en_o(en[ch])
            );

            // Any of the three error conditions marks the channel.
            assign group_error_source_reg[ch] = flags[ch].overrun |
                flags[ch].framing | flags[ch].parity;

            assign ch_rdata[ch] = {
                20'h0,
                en[ch],
                1'b0,
                flags[ch].parity,
                flags[ch].framing,
                flags[ch].overrun,
                group_error_source_reg[ch],
                flags[ch].tx_end,
                flags[ch].tx_empty,
                flags[ch].rx_full
            };
        end
    endgenerate

    logic [31:0] rd_word;
    logic [1:0] ev_set;
    logic gerr_next;

    always_comb begin
        st_next = st_reg;

        // Per-channel requests only leave when their enable is set.
        for (int i = 0; i < `SIRQ_NCH; i++) begin
            st_next.rf_req[i] = flags[i].rx_full & en[i][0];
            st_next.te_req[i] = flags[i].tx_empty & en[i][1];
            st_next.tn_req[i] = flags[i].tx_end & en[i][2];
        end

        // Errors never get a vector per channel; they meet in one
        // request, masked per channel without touching the flags.
        gerr_next = |(group_error_source_reg &
            st_reg.group_error_enable_reg &
            {`SIRQ_NCH{1'b1}});
        st_next.err_req = gerr_next;

        ev_set = '0;
        ev_set[`SIRQ_IS_GERR] = gerr_next & ~st_reg.err_req;
        ev_set[`SIRQ_IS_REFUSED] = refused;

        if (bus.wr) begin
            case (bus.addr)
                `SIRQ_GEN_OFS: begin
                    st_next.group_error_enable_reg =
                        bus.wdata[`SIRQ_NCH-1:0];
                end
                `SIRQ_IMASK_OFS: begin
                    st_next.imask = bus.wdata[1:0];
                end
                default: begin
                end
            endcase
        end

        rd_word = 32'h0;
        if (bus.rd) begin
            case (bus.addr)
                `SIRQ_PROT_OFS: begin
                    rd_word = {31'h0, unlocked};
                end
                `SIRQ_STOP_OFS: begin
                    rd_word = {20'h0, stop};
                end
                `SIRQ_GSRC_OFS: begin
                    rd_word = {20'h0, group_error_source_reg};
                end
                `SIRQ_GEN_OFS: begin
                    rd_word = {20'h0, st_reg.group_error_enable_reg};
                end
                `SIRQ_ISTAT_OFS: begin
                    rd_word = {30'h0, st_reg.istat};
                end
                `SIRQ_IMASK_OFS: begin
                    rd_word = {30'h0, st_reg.imask};
                end
                default: begin
                    if (ch_hit) begin
                        rd_word = ch_rdata[ch_idx];
                    end
                end
            endcase
        end
        st_next.rdata = rd_word;

        // Reading the status clears it, but a new event in the same
        // cycle stays latched.
        if (bus.rd && bus.addr == `SIRQ_ISTAT_OFS) begin
            st_next.istat = ev_set;
        end else begin
            st_next.istat = st_reg.istat | ev_set;
        end
        st_next.irq = |(st_next.istat & st_next.imask);
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata_o = st_reg.rdata;
    assign receive_full_request_o = st_reg.rf_req;
    assign transmit_empty_request_o = st_reg.te_req;
    assign transmit_end_request_o = st_reg.tn_req;
    assign receive_error_request_o = st_reg.err_req;
    assign chan_stop_o = stop;
    assign irq_o = st_reg.irq;
endmodule // sirq_top

`default_nettype wire

// *** verif/sirq_checker.sv ***
// Purpose: Port-level checks of the serial interrupt routing block.
// Assumes: One core clock, synchronous active-low reset.
// Notes:   Bound to the top module; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "sirq_map.svh"

module sirq_checker import sirq_pkg::*; (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [`SIRQ_AW-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire sirq_flags_t [`SIRQ_NCH-1:0] evt_i,
    input wire sirq_ack_t [`SIRQ_NCH-1:0] ack_i,
    input wire logic [`SIRQ_NCH-1:0] receive_full_request_o,
    input wire logic [`SIRQ_NCH-1:0] transmit_empty_request_o,
    input wire logic [`SIRQ_NCH-1:0] transmit_end_request_o,
    input wire logic receive_error_request_o,
    input wire logic [`SIRQ_NCH-1:0] chan_stop_o,
    input wire logic irq_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic err_any;
    logic [1:0] cfg_q;
    logic [1:0] stop_q;
    always_comb begin
        err_any = 1'b0;
        for (int n = 0; n < `SIRQ_NCH; n++)
            err_any = err_any | evt_i[n].overrun | evt_i[n].framing | evt_i[n].parity;
    end
    // Writes that may raise the group request or the interrupt a cycle or two later.
    always_ff @(posedge core_clk_i) begin
        cfg_q <= {cfg_q[0], wr_i && (addr_i inside {`SIRQ_GEN_OFS, `SIRQ_IMASK_OFS, `SIRQ_STOP_OFS})};
        stop_q <= {stop_q[0], wr_i && addr_i == `SIRQ_STOP_OFS};
    end
    sequence s_rx_ack0;
        ack_i[0].rx_full && !evt_i[0].rx_full;
    endsequence
    sequence s_all_stopped;
        (&chan_stop_o) [*4];
    endsequence
    a_stop_reset: assert property ($rose(rst_b_i) |-> chan_stop_o == `SIRQ_STOP_RST)
        else $error("stop vector not all set after reset");
    a_stop_idle: assert property (!(|(chan_stop_o & $past(chan_stop_o) & $past(chan_stop_o, 2) &
        (receive_full_request_o | transmit_empty_request_o | transmit_end_request_o)))) else $error("stopped request");
    a_stop_quiet: assert property (s_all_stopped |-> !receive_error_request_o)
        else $error("group request while all stopped");
    a_ack_clear: assert property (s_rx_ack0 |-> ##2 !receive_full_request_o[0])
        else $error("accepted request did not clear");
    a_stop_write: assert property ($changed(chan_stop_o) |-> |stop_q)
        else $error("stop vector changed without a write");
    a_err_cause: assert property ($rose(receive_error_request_o) |-> $past(err_any, 2) || |cfg_q)
        else $error("group request rose without an error");
    a_irq_cause: assert property ($rose(irq_o) |-> receive_error_request_o || |cfg_q)
        else $error("interrupt rose without a cause");
    a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data outside its cycle");
endmodule // sirq_checker

bind sirq_top sirq_checker chk (.*);
`default_nettype wire

// *** verif/sirq_cpu_model.sv ***
// Purpose: Processor interrupt controller that accepts channel requests.
// Assumes: Requests are registered levels on the core clock.
// Notes:   A gap after each accept lets the requests fall before the next look.
`timescale 1ns/1ps
`default_nettype none
`include "sirq_map.svh"

module sirq_cpu_model import sirq_pkg::*; (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic take_i,
    input wire logic slow_i,
    input wire logic [`SIRQ_NCH-1:0] rf_i,
    input wire logic [`SIRQ_NCH-1:0] te_i,
    input wire logic [`SIRQ_NCH-1:0] tn_i,
    output sirq_ack_t [`SIRQ_NCH-1:0] ack_o
);
    logic [3:0] wait_q;
    always @(posedge core_clk_i) begin
        ack_o <= '0;
        if (!rst_b_i)
            wait_q <= 4'h0;
        else if (wait_q != 4'h0)
            wait_q <= wait_q - 4'h1;
        else if (take_i && |{rf_i, te_i, tn_i}) begin
            for (int n = 0; n < `SIRQ_NCH; n++)
                ack_o[n] <= {tn_i[n], te_i[n], rf_i[n]};
            wait_q <= slow_i ? 4'hb : 4'h3;
        end
    end
endmodule // sirq_cpu_model
`default_nettype wire

// *** verif/serial_irq_group_routing_tb_top.sv ***
// Purpose: Self-checking bench of the serial interrupt routing block.
// Assumes: Reads are checked from a queue of expected words.
// Notes:   Fixed seed, so every run draws the same channels.
`timescale 1ns/1ps
`default_nettype none
`include "sirq_map.svh"

module serial_irq_group_routing_tb_top;
    import sirq_pkg::*;
    logic core_clk_i, rst_b_i, wr_i, rd_i, take, slow;
    logic pend = 1'b0;
    logic [7:0] addr_i;
    logic [31:0] wdata_i, rdata_o;
    sirq_flags_t [`SIRQ_NCH-1:0] evt_i;
    sirq_ack_t [`SIRQ_NCH-1:0] ack_i;
    logic [`SIRQ_NCH-1:0] receive_full_request_o, transmit_empty_request_o, transmit_end_request_o, chan_stop_o;
    logic receive_error_request_o, irq_o;
    logic [31:0] exp_q[$];
    int n_mismatch = 0, check_count = 0, cyc = 0, k, c;
    sirq_top dut (.*);
    sirq_cpu_model cpu (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .take_i(take), .slow_i(slow),
        .rf_i(receive_full_request_o), .te_i(transmit_empty_request_o), .tn_i(transmit_end_request_o), .ack_o(ack_i));
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(negedge core_clk_i) begin
        if (pend)
            chk(rdata_o, exp_q.pop_front());
        pend = rd_i;
    end
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            stop_test();
        end
    end
    function automatic logic [7:0] ca(int n);
        return 8'h40 + 8'(4 * n);
    endfunction
    task automatic tick(int n);
        repeat (n) @(negedge core_clk_i);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge core_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        exp_q.push_back(e);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
    endtask
    task automatic pulse(int n, logic [5:0] v);
        @(posedge core_clk_i);
        evt_i[n] <= v;
        @(posedge core_clk_i);
        evt_i[n] <= '0;
    endtask
    initial begin
        {rst_b_i, wr_i, rd_i, take, slow} = '0;
        addr_i = '0;
        wdata_i = '0;
        evt_i = '0;
        void'($urandom(42));
        repeat (4) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        rd(`SIRQ_STOP_OFS, 32'hfff);
        rd(8'hfc, 32'h0);
        wr(`SIRQ_IMASK_OFS, 32'h2);
        wr(`SIRQ_STOP_OFS, 32'h0);
        tick(2);
        chk(32'(irq_o), 32'h1);
        chk(32'(chan_stop_o), 32'hfff);
        rd(`SIRQ_STOP_OFS, 32'hfff);
        rd(`SIRQ_ISTAT_OFS, 32'h2);
        rd(`SIRQ_ISTAT_OFS, 32'h0);
        wr(`SIRQ_PROT_OFS, 32'h5a01);
        rd(`SIRQ_PROT_OFS, 32'h0);
        wr(`SIRQ_PROT_OFS, 32'ha501);
        rd(`SIRQ_PROT_OFS, 32'h1);
        wr(`SIRQ_STOP_OFS, 32'h0);
        rd(`SIRQ_STOP_OFS, 32'h0);
        wr(`SIRQ_PROT_OFS, 32'ha500);
        $display("test protect done");
        for (int n = 0; n < `SIRQ_NCH; n++) begin
            k = $urandom % 3;
            pulse(n, (6'h08 << k) | 6'h07);
            rd(ca(n), 32'h0f | (32'h10 << k));
            rd(`SIRQ_GSRC_OFS, 32'h1 << n);
            wr(ca(n), 32'h77);
            rd(ca(n), 32'h0);
        end
        $display("test poll done");
        c = $urandom % `SIRQ_NCH;
        wr(`SIRQ_IMASK_OFS, 32'h1);
        wr(`SIRQ_GEN_OFS, 32'h1 << c);
        pulse(c, 6'h10);
        tick(3);
        chk(32'(receive_error_request_o), 32'h1);
        chk(32'(irq_o), 32'h1);
        rd(`SIRQ_ISTAT_OFS, 32'h1);
        wr(`SIRQ_GEN_OFS, 32'h0);
        tick(3);
        chk(32'(receive_error_request_o), 32'h0);
        chk(32'(irq_o), 32'h0);
        rd(`SIRQ_GSRC_OFS, 32'h1 << c);
        wr(ca(c), 32'h20);
        rd(`SIRQ_GSRC_OFS, 32'h0);
        $display("test group done");
        wr(ca(0), 32'h700);
        pulse(0, 6'h07);
        tick(3);
        chk(32'({receive_full_request_o[0], transmit_empty_request_o[0], transmit_end_request_o[0]}), 32'h7);
        slow <= 1'($urandom % 2);
        take <= 1'b1;
        tick(16);
        chk(32'({receive_full_request_o[0], transmit_empty_request_o[0], transmit_end_request_o[0]}), 32'h0);
        rd(ca(0), 32'h700);
        take <= 1'b0;
        $display("test accept done");
        wr(`SIRQ_PROT_OFS, 32'ha501);
        wr(`SIRQ_STOP_OFS, 32'hfff);
        pulse(0, 6'h3f);
        rd(ca(0), 32'h0);
        wr(ca(0), 32'h700);
        rd(ca(0), 32'h0);
        rd(`SIRQ_GSRC_OFS, 32'h0);
        tick(2);
        chk(32'(chan_stop_o), 32'hfff);
        $display("test stop done");
        stop_test();
    end
endmodule // serial_irq_group_routing_tb_top
`default_nettype wire
